// [rtl/shift_subtract_alu.sv]
// One-cycle shift-left and subtract datapath slice of the processor core.
// How it works
// - Register-count shift: base shifted by count register, only N and Z.
// - Literal shift: base shifted left by 5-bit literal, only N and Z.
// - File borrow subtract: f minus W minus not C, back to file.
// - Same with working register destination; file left unchanged.
// - Literal borrow subtract: Wn minus lit10 minus not C into Wn.
// - Three-register borrow subtract: base minus source minus not C.
// - Short literal borrow subtract: base minus lit5 minus not C.
// - File reverse borrow subtract: W minus f minus not C, to file.
// - Same with working register destination.
// - Three-register reverse: source minus base minus not C.
// - Literal reverse: lit5 minus base minus not C, all five flags.
`timescale 1ns/1ps
module shift_subtract_alu (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Request from decode and register file
  input wire ss_alu_pkg::req_s req,
  input wire logic carry_in,
  // Result to register file and status register
  output ss_alu_pkg::res_s res
);
  import ss_alu_pkg::*;

  // ----------------------------------------
  // Operand selection
  // ----------------------------------------
  logic [15:0] opa;
  logic [15:0] opb;
  logic [15:0] diff;
  logic [15:0] shifted;
  logic use_carry;
  logic is_shift;
  flags_s sub_flags;
  res_s next_res;

  function automatic logic [15:0] second_operand(input req_s r);
    logic [15:0] v;
    v = r.default_working_register;
    unique case (r.form)
      form_file, form_file_default_working_register: v = r.default_working_register;
      form_lit10: v = {6'h00, r.lit10};
      form_reg_reg: v = r.source_register;
      form_reg_lit5: v = {11'h000, r.lit5};
    endcase
    return v;
  endfunction

  function automatic logic [15:0] first_operand(input req_s r);
    logic [15:0] v;
    v = r.base_register;
    unique case (r.form)
      form_file, form_file_default_working_register: v = r.file_value;
      form_lit10: v = r.base_register;
      form_reg_reg, form_reg_lit5: v = r.base_register;
    endcase
    return v;
  endfunction

  always_comb begin
    is_shift = (req.op == shift_left_op);
    use_carry = (req.op == subtract_borrow_op)
      || (req.op == reverse_subtract_borrow_op);
    opa = first_operand(req);
    opb = second_operand(req);
    if ((req.op == reverse_subtract_op)
        || (req.op == reverse_subtract_borrow_op)) begin
      opa = second_operand(req);
      opb = first_operand(req);
    end
  end

  // Plain forms present a set carry so no borrow enters.
  ss_sub_core u_sub (
    .minuend(opa),
    .subtrahend(opb),
    .carry_in(use_carry ? carry_in : 1'b1),
    .diff(diff),
    .flags(sub_flags)
  );

  // ----------------------------------------
  // Shift and result assembly
  // ----------------------------------------
  always_comb begin
    shifted = req.base_register;
    if (req.form == form_reg_lit5) begin
      shifted = req.base_register << req.lit5;
    end else begin
      shifted = req.base_register << req.source_register[SHAMT_W-1:0];
    end
    next_res = '0;
    next_res.valid = req.valid;
    if (is_shift) begin
      next_res.result = shifted;
      next_res.to_dest = 1'b1;
      next_res.flags.negative = shifted[DATA_MSB];
      next_res.flags.zero = (shifted == ZERO_WORD);
      next_res.flag_write.negative = 1'b1;
      next_res.flag_write.zero = 1'b1;
    end else begin
      next_res.result = diff;
      next_res.flags = sub_flags;
      next_res.flag_write = '1;
      next_res.to_file = (req.form == form_file);
      next_res.to_default_working_register = (req.form == form_file_default_working_register);
      next_res.to_dest = (req.form == form_lit10)
        || (req.form == form_reg_reg) || (req.form == form_reg_lit5);
    end
  end

  // ----------------------------------------
  // Result register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      res <= '0;
    end else if (req.valid) begin
      res <= next_res;
    end else begin
      res <= '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  shift_flags_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == shift_left_op |=> res.valid
      && res.flag_write == 5'b00101)
    else $error("shift updates wrong flags");

  lit_shift_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == shift_left_op && req.form == form_reg_lit5
      |=> res.result == ($past(req.base_register)
      << $past(req.lit5)))
    else $error("literal shift result wrong");

  file_borrow_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == subtract_borrow_op && req.form == form_file
      |=> res.to_file && !res.to_default_working_register && res.result ==
      16'($past(req.file_value) - $past(req.default_working_register)
      - {15'h0000, !$past(carry_in)}))
    else $error("file borrow subtract wrong");

  default_working_register_borrow_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == subtract_borrow_op
      && req.form == form_file_default_working_register |=> res.to_default_working_register && !res.to_file)
    else $error("working destination not honoured");

  lit10_borrow_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == subtract_borrow_op && req.form == form_lit10
      |=> res.to_dest && res.result == 16'($past(req.base_register)
      - {6'h00, $past(req.lit10)} - {15'h0000, !$past(carry_in)}))
    else $error("lit10 borrow subtract wrong");

  reg_borrow_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == subtract_borrow_op && req.form == form_reg_reg
      |=> res.result == 16'($past(req.base_register)
      - $past(req.source_register) - {15'h0000, !$past(carry_in)}))
    else $error("register borrow subtract wrong");

  rev_lit_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == reverse_subtract_borrow_op
      && req.form == form_reg_lit5 |=> res.result ==
      16'({11'h000, $past(req.lit5)} - $past(req.base_register)
      - {15'h0000, !$past(carry_in)}))
    else $error("reverse literal subtract wrong");

  rev_file_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == reverse_subtract_borrow_op
      && req.form == form_file |=> res.to_file && res.result ==
      16'($past(req.default_working_register) - $past(req.file_value)
      - {15'h0000, !$past(carry_in)}))
    else $error("reverse file subtract wrong");

  plain_carry_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == subtract_op && req.form == form_reg_reg
      |=> res.flags.carry == ($past(req.base_register)
      >= $past(req.source_register)))
    else $error("plain subtract carry wrong");

  count_shift_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == shift_left_op && req.form != form_reg_lit5
      |=> res.to_dest && res.result == ($past(req.base_register)
      << $past(req.source_register[SHAMT_W-1:0])))
    else $error("count register shift result wrong");

  shift_nz_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == shift_left_op
      |=> res.flags.negative == res.result[DATA_MSB]
      && res.flags.zero == (res.result == ZERO_WORD))
    else $error("shift flag values wrong");

  short_lit_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == subtract_borrow_op && req.form == form_reg_lit5
      |=> res.to_dest && res.result == 16'($past(req.base_register)
      - {11'h000, $past(req.lit5)} - {15'h0000, !$past(carry_in)}))
    else $error("short literal borrow subtract wrong");

  rev_default_working_register_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == reverse_subtract_borrow_op
      && req.form == form_file_default_working_register |=> res.to_default_working_register && !res.to_file
      && res.result == 16'($past(req.default_working_register)
      - $past(req.file_value) - {15'h0000, !$past(carry_in)}))
    else $error("reverse working destination wrong");

  rev_reg_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == reverse_subtract_borrow_op
      && req.form == form_reg_reg |=> res.to_dest && res.result ==
      16'($past(req.source_register) - $past(req.base_register)
      - {15'h0000, !$past(carry_in)}))
    else $error("reverse register subtract wrong");

  nib_carry_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == subtract_op && req.form == form_reg_reg
      |=> res.flags.digit_carry_flag
      == ($past(req.base_register[NIB_MSB:0])
      >= $past(req.source_register[NIB_MSB:0])))
    else $error("digit carry not inverted borrow");

  plain_reg_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.op == subtract_op && req.form == form_reg_reg
      |=> res.result == 16'($past(req.base_register)
      - $past(req.source_register)))
    else $error("plain subtract result wrong");

endmodule

// [rtl/ss_alu_pkg.sv]
// Package with operation codes, widths and flag layout for the shift/subtract slice.
package ss_alu_pkg;

  // ----------------------------------------
  // Widths and field positions
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int LIT5_W = 5;
  localparam int LIT10_W = 10;
  localparam int NIB_MSB = 3;
  localparam int SHAMT_W = 4;
  localparam int DATA_MSB = 15;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] WORD_MASK = 16'hffff;

  // ----------------------------------------
  // Operation and operand selections
  // ----------------------------------------
  typedef enum logic [2:0] {
    shift_left_op = 3'b000,
    subtract_op = 3'b001,
    subtract_borrow_op = 3'b010,
    reverse_subtract_op = 3'b011,
    reverse_subtract_borrow_op = 3'b100
  } op_e;

  typedef enum logic [2:0] {
    form_file = 3'b000,
    form_file_default_working_register = 3'b001,
    form_lit10 = 3'b010,
    form_reg_reg = 3'b011,
    form_reg_lit5 = 3'b100
  } form_e;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic negative;
    logic overflow_flag;
    logic zero;
  } flags_s;

  typedef struct packed {
    logic valid;
    op_e op;
    form_e form;
    logic [15:0] file_value;
    logic [15:0] default_working_register;
    logic [15:0] base_register;
    logic [15:0] source_register;
    logic [9:0] lit10;
    logic [4:0] lit5;
  } req_s;

  typedef struct packed {
    logic valid;
    logic to_file;
    logic to_default_working_register;
    logic to_dest;
    logic [15:0] result;
    flags_s flags;
    flags_s flag_write;
  } res_s;

endpackage

// [rtl/ss_sub_core.sv]
// Combinational subtract core with inverted-borrow carry and flag generation.
`timescale 1ns/1ps
module ss_sub_core (
  // Operands
  input wire logic [15:0] minuend,
  input wire logic [15:0] subtrahend,
  input wire logic carry_in,
  // Result
  output logic [15:0] diff,
  output ss_alu_pkg::flags_s flags
);
  import ss_alu_pkg::*;

  logic [16:0] full;
  logic [4:0] low;

  // Adding the inverted subtrahend plus carry gives a - b - !c; carry out is
  // then set exactly when no borrow occurred.
  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {16'h0000, carry_in};
    low = {1'b0, minuend[NIB_MSB:0]} + {1'b0, ~subtrahend[NIB_MSB:0]}
      + {4'h0, carry_in};
    diff = full[DATA_MSB:0];
    flags.carry = full[DATA_W];
    flags.digit_carry_flag = low[NIB_MSB + 1];
    flags.negative = diff[DATA_MSB];
    flags.overflow_flag = (minuend[DATA_MSB] != subtrahend[DATA_MSB])
      && (diff[DATA_MSB] != minuend[DATA_MSB]);
    flags.zero = (diff == ZERO_WORD);
  end

endmodule

// [verification/tb_top.sv]
// Self-checking bench for the shift and subtract datapath slice.
`timescale 1ns/1ps
`define CHECK(g, e) chk(32'(g), 32'(e))
module tb_top;
  import ss_alu_pkg::*;

  typedef struct packed {
    op_e op;
    form_e form;
    logic [15:0] f, w, b, s;
    logic [9:0] l10;
    logic [4:0] l5;
    logic cin;
  } row_s;

  logic clk, nrst, carry_in;
  req_s req;
  res_s res;
  row_s rows[$];
  res_s exps[$];
  int n_mismatch, cmp_count;
  flags_s m;

  shift_subtract_alu u_shift_subtract_alu (
    .clk(clk), .nrst(nrst), .req(req), .carry_in(carry_in), .res(res)
  );

  always #10 clk = ~clk;

  // ----
  // Reference model and helpers
  // ----
  function automatic res_s model(row_s r);
    logic [16:0] d;
    logic [4:0] n;
    logic [15:0] a, x, t;
    logic bi;
    res_s e;
    e = '0;
    e.valid = 1'b1;
    if (r.op == shift_left_op) begin
      e.to_dest = 1'b1;
      e.result = r.b << (r.form == form_reg_lit5 ? r.l5 : r.s[3:0]);
      e.flag_write = 5'h05;
      e.flags.negative = e.result[15];
      e.flags.zero = (e.result == 16'h0000);
      return e;
    end
    a = r.b;
    e.to_dest = 1'b1;
    case (r.form)
      form_file, form_file_default_working_register: begin
        a = r.f;
        x = r.w;
        e.to_dest = 1'b0;
        e.to_file = (r.form == form_file);
        e.to_default_working_register = (r.form == form_file_default_working_register);
      end
      form_lit10: x = {6'h00, r.l10};
      form_reg_reg: x = r.s;
      default: x = {11'h000, r.l5};
    endcase
    if (r.op == reverse_subtract_op || r.op == reverse_subtract_borrow_op) begin
      t = a;
      a = x;
      x = t;
    end
    bi = (r.op == subtract_borrow_op || r.op == reverse_subtract_borrow_op)
      ? ~r.cin : 1'b0;
    d = {1'b0, a} - {1'b0, x} - 17'(bi);
    n = {1'b0, a[3:0]} - {1'b0, x[3:0]} - 5'(bi);
    e.result = d[15:0];
    e.flags = {~d[16], ~n[4], d[15], (a[15] != x[15]) && (d[15] != a[15]),
      d[15:0] == 16'h0000};
    e.flag_write = 5'h1f;
    return e;
  endfunction

  function automatic logic [29:0] pk(res_s r, flags_s m);
    return {r.valid, r.to_file, r.to_default_working_register, r.to_dest, r.result,
      r.flags & m, r.flag_write};
  endfunction

  task automatic add_row(op_e o, form_e fm, logic [15:0] f, w, b, s,
      logic [9:0] l10, logic [4:0] l5, logic c);
    row_s r;
    r = '{o, fm, f, w, b, s, l10, l5, c};
    rows.push_back(r);
    exps.push_back(model(r));
  endtask

  task automatic drive(row_s r, logic v);
    req = '{v, r.op, r.form, r.f, r.w, r.b, r.s, r.l10, r.l5};
    carry_in = r.cin;
  endtask

  task automatic chk(logic [31:0] g, logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----
  // Stimulus
  // ----
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    req = '0;
    carry_in = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    add_row(shift_left_op, form_reg_reg, 0, 0, 16'h8001, 16'h0001, 0, 0, 0);
    add_row(shift_left_op, form_reg_reg, 0, 0, 16'h1234, 16'hfff0, 0, 0, 1);
    add_row(shift_left_op, form_reg_reg, 0, 0, 16'h0001, 16'h000f, 0, 0, 0);
    add_row(shift_left_op, form_reg_lit5, 0, 0, 16'h8000, 16'hffff, 0, 1, 1);
    add_row(shift_left_op, form_reg_lit5, 0, 0, 16'h0003, 16'h0001, 0, 30, 0);
    for (int o = 1; o < 5; o++) begin
      for (int fm = 0; fm < 5; fm++) begin
        for (int c = 0; c < 2; c++) begin
          add_row(op_e'(o[2:0]), form_e'(fm[2:0]), 16'h0005, 16'h0005,
            16'h8000, 16'h0001, 10'h3ff, 5'h1f, c[0]);
          add_row(op_e'(o[2:0]), form_e'(fm[2:0]), 16'h7ff0, 16'h8009,
            16'h0010, 16'h0010, 10'h010, 5'h10, c[0]);
        end
      end
    end
    @(negedge clk);
    drive(rows[0], 1'b1);
    @(negedge clk);
    `CHECK(res, 0);
    req.valid = 1'b0;
    nrst = 1'b1;
    @(negedge clk);
    `CHECK(res, 0);
    foreach (rows[i]) begin
      drive(rows[i], 1'b1);
      @(negedge clk);
      m = exps[i].flag_write;
      `CHECK(pk(res, m), pk(exps[i], m));
      `CHECK(res.result, exps[i].result);
      `CHECK(res.flags & m, exps[i].flags & m);
    end
    req.valid = 1'b0;
    @(negedge clk);
    `CHECK(res, 0);
    drive(rows[7], 1'b1);
    @(negedge clk);
    `CHECK(res.result, exps[7].result);
    nrst = 1'b0;
    @(negedge clk);
    `CHECK(res, 0);
    close_out();
  end
endmodule
